//--- logic/spt_clock_ctrl.sv
// system clock prescaler, oscillator trim and sleep control with AHB-Lite slave
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - first edge after reset release loads factory trim value into trim
// - software rewrites trim anytime, retunes immediately
// - trim bit 7 picks low or high range
// - low seven trim bits tune monotonically
// - divider control register layout and address
// - divider control bits 6..4 read zero
// - unlock set only by exact unlock word
// - unlock clears after four cycles or select write
// - repeated unlock write neither restarts nor clears
// - reset select from divide-by-eight fuse
// - unlocked select accepts any value
// - codes 0..8 divide by two to code
// - divided clock drives core and peripherals
// - idle stops core and flash, wakes broadly
// - deep modes wake on external level, pin change or watchdog only
// - sleep needs allow bit, mode field selects
// - power-down stops oscillator, few wake sources
// - standby like power-down, oscillator on, six cycles
// - wake halts core four cycles after start-up
module spt_clock_ctrl
    import spt_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // factory straps, caught after reset release
    input wire logic [7:0] factory_trim,
    input wire logic divide_by_eight_fuse,
    // core sleep instruction and interrupt requests
    input wire logic sleep_exec,
    input wire logic ext_irq_level,
    input wire logic ext_irq_edge,
    input wire logic pin_change_irq,
    input wire logic mem_ready_irq,
    input wire logic conv_done_irq,
    input wire logic other_irq,
    input wire logic wdt_irq,
    // oscillator control
    output logic [7:0] oscillator_trim,
    output logic trim_range_select,
    output logic [6:0] trim_fine_tune,
    output logic osc_run,
    // clock domain enables and core halt
    output logic cpu_clk_en,
    output logic flash_clk_en,
    output logic io_clk_en,
    output logic adc_clk_en,
    output logic core_halt,
    output logic wake_done
);
    spt_ctl_if ctl ();

    logic load_done_reg;
    logic [7:0] trim_reg;
    logic [3:0] div_select_reg;
    logic divider_change_unlock_reg;
    logic [2:0] unlock_cnt_reg;
    logic sleep_allow_bit_reg;
    spt_mode_type mode_field_reg;
    spt_mode_type act_mode_reg;
    spt_state_type state_reg;
    logic [2:0] wait_cnt_reg;
    logic wake_done_reg;

    // bus address phase capture
    logic dph_valid_reg;
    logic dph_write_reg;
    logic [7:0] dph_idx_reg;
    logic [31:0] rd_word;
    logic addr_phase;
    logic wr_dcc;
    logic wr_trim;
    logic wr_mcu;
    logic [7:0] wbyte;
    logic unlock_set;
    logic sel_write;

    // word index decode; anything outside the low window is unmapped
    function automatic logic idx_hit(input logic [31:0] addr, input logic [7:0] idx);
        return (addr[31:10] == 22'h000000) && (addr[9:2] == idx);
    endfunction

    // start-up cycles counted before the post-wake halt
    function automatic logic [2:0] startup_cycles(input spt_mode_type m);
        logic [2:0] n;
        n = 3'h0;
        if (m == SLP_PDOWN) begin
            n = PDOWN_WAKE_CYC;
        end else if (m == SLP_STANDBY) begin
            n = STANDBY_WAKE_CYC;
        end
        return n;
    endfunction

    spt_divider u_divider (
        .mclk(mclk),
        .resetn(resetn),
        .ctl(ctl.divider)
    );

    spt_wake_qual u_wake_qual (
        .ctl(ctl.waker),
        .ext_irq_level(ext_irq_level),
        .ext_irq_edge(ext_irq_edge),
        .pin_change_irq(pin_change_irq),
        .mem_ready_irq(mem_ready_irq),
        .conv_done_irq(conv_done_irq),
        .other_irq(other_irq),
        .wdt_irq(wdt_irq)
    );

    assign ctl.div_sel = div_select_reg;
    assign ctl.sleep_mode = act_mode_reg;

    // zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_phase = hsel && htrans[1] && hready;

    // address phase is held for the following data phase
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dph_valid_reg <= 1'b0;
            dph_write_reg <= 1'b0;
            dph_idx_reg <= 8'h00;
        end else if (hready) begin
            dph_valid_reg <= addr_phase && (haddr[31:10] == 22'h000000);
            dph_write_reg <= hwrite;
            dph_idx_reg <= haddr[9:2];
        end
    end

    // write strobes, taken in the data phase from the low byte lane
    assign wbyte = hwdata[7:0];
    assign wr_dcc = dph_valid_reg && dph_write_reg && (dph_idx_reg == IDX_DIV_CTRL);
    assign wr_trim = dph_valid_reg && dph_write_reg && (dph_idx_reg == IDX_OSC_TRIM);
    assign wr_mcu = dph_valid_reg && dph_write_reg && (dph_idx_reg == IDX_MCU_CTRL);

    // unlock only on the exact word, and never re-armed while open
    assign unlock_set = wr_dcc && (wbyte == DCC_UNLOCK_WORD)
        && !divider_change_unlock_reg;
    // select write: unlocked and unlock bit written as zero
    assign sel_write = wr_dcc && divider_change_unlock_reg && !wbyte[DCC_UNLOCK_BIT];

    // straps are caught on the first edge after reset release
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            load_done_reg <= 1'b0;
        end else begin
            load_done_reg <= 1'b1;
        end
    end

    // oscillator trim: factory value after reset, then free software access
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            trim_reg <= TRIM_RST;
        end else if (!load_done_reg) begin
            trim_reg <= factory_trim;
        end else if (wr_trim) begin
            trim_reg <= wbyte;
        end
    end

    // trim drives the oscillator straight from the register
    assign oscillator_trim = trim_reg;
    assign trim_range_select = trim_reg[TRIM_RANGE_BIT];
    assign trim_fine_tune = trim_reg[TRIM_RANGE_BIT-1:0];

    // divider select: fuse dependent start, changed only when unlocked
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            div_select_reg <= DCC_SEL_RST_PLAIN;
        end else if (!load_done_reg) begin
            div_select_reg <= divide_by_eight_fuse ? DCC_SEL_RST_DIV8
                : DCC_SEL_RST_PLAIN;
        end else if (sel_write) begin
            div_select_reg <= wbyte[DCC_SEL_MSB:0];
        end
        // locked writes fall through and change nothing
    end

    // unlock window counted in divided core cycles
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            divider_change_unlock_reg <= 1'b0;
            unlock_cnt_reg <= 3'h0;
        end else if (unlock_set) begin
            divider_change_unlock_reg <= 1'b1;
            unlock_cnt_reg <= 3'h0;
        end else if (sel_write) begin
            divider_change_unlock_reg <= 1'b0;
            unlock_cnt_reg <= 3'h0;
        end else if (divider_change_unlock_reg && ctl.div_tick) begin
            if (unlock_cnt_reg == 3'(UNLOCK_CYC - 3'h1)) begin
                divider_change_unlock_reg <= 1'b0;
                unlock_cnt_reg <= 3'h0;
            end else begin
                unlock_cnt_reg <= 3'(unlock_cnt_reg + 3'h1);
            end
        end
    end

    // sleep allow bit and mode field
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sleep_allow_bit_reg <= 1'b0;
            mode_field_reg <= SLP_IDLE;
        end else if (wr_mcu) begin
            sleep_allow_bit_reg <= wbyte[MCU_SLEEP_ALLOW_BIT];
            mode_field_reg <= spt_mode_type'(wbyte[MCU_MODE_MSB:MCU_MODE_LSB]);
        end
    end

    // sleep sequencer: run, sleep, oscillator start-up, post-wake halt
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_RUN;
            act_mode_reg <= SLP_IDLE;
            wait_cnt_reg <= 3'h0;
            wake_done_reg <= 1'b0;
        end else begin
            wake_done_reg <= 1'b0;
            unique case (state_reg)
                ST_RUN: begin
                    if (sleep_exec && sleep_allow_bit_reg) begin
                        state_reg <= ST_SLEEP;
                        act_mode_reg <= mode_field_reg;
                    end
                end
                ST_SLEEP: begin
                    if (ctl.wake_hit) begin
                        wait_cnt_reg <= 3'h0;
                        if (startup_cycles(act_mode_reg) == 3'h0) begin
                            state_reg <= ST_HALT;
                        end else begin
                            state_reg <= ST_START;
                        end
                    end
                end
                ST_START: begin
                    if (wait_cnt_reg == 3'(startup_cycles(act_mode_reg) - 3'h1)) begin
                        state_reg <= ST_HALT;
                        wait_cnt_reg <= 3'h0;
                    end else begin
                        wait_cnt_reg <= 3'(wait_cnt_reg + 3'h1);
                    end
                end
                ST_HALT: begin
                    if (wait_cnt_reg == 3'(WAKE_HALT_CYC - 3'h1)) begin
                        state_reg <= ST_RUN;
                        wait_cnt_reg <= 3'h0;
                        wake_done_reg <= 1'b1;
                    end else begin
                        wait_cnt_reg <= 3'(wait_cnt_reg + 3'h1);
                    end
                end
                default: begin
                    state_reg <= ST_RUN;
                    wait_cnt_reg <= 3'h0;
                end
            endcase
        end
    end

    // clock domain gating from the divided enable and sleep state
    always_comb begin
        cpu_clk_en = ctl.div_tick && (state_reg == ST_RUN);
        flash_clk_en = ctl.div_tick && (state_reg == ST_RUN);
        io_clk_en = ctl.div_tick && ((state_reg == ST_RUN)
            || ((state_reg == ST_SLEEP) && (act_mode_reg == SLP_IDLE)));
        adc_clk_en = ctl.div_tick && ((state_reg == ST_RUN)
            || ((state_reg == ST_SLEEP) && ((act_mode_reg == SLP_IDLE)
            || (act_mode_reg == SLP_CONV_QUIET))));
        // only power-down stops the oscillator
        osc_run = !((state_reg == ST_SLEEP) && (act_mode_reg == SLP_PDOWN));
    end

    assign core_halt = (state_reg != ST_RUN);
    assign wake_done = wake_done_reg;

    // read mux; reserved and unmapped bits read zero
    always_comb begin
        rd_word = 32'h00000000;
        unique case (dph_idx_reg)
            IDX_DIV_CTRL: begin
                rd_word[DCC_UNLOCK_BIT] = divider_change_unlock_reg;
                rd_word[DCC_SEL_MSB:0] = div_select_reg;
            end
            IDX_OSC_TRIM: rd_word[7:0] = trim_reg;
            IDX_MCU_CTRL: begin
                rd_word[MCU_SLEEP_ALLOW_BIT] = sleep_allow_bit_reg;
                rd_word[MCU_MODE_MSB:MCU_MODE_LSB] = mode_field_reg;
            end
            IDX_SLEEP_STAT: begin
                rd_word[3:0] = state_reg;
                rd_word[5:4] = act_mode_reg;
                rd_word[6] = osc_run;
            end
            default: rd_word = 32'h00000000;
        endcase
        if (!dph_valid_reg || dph_write_reg) begin
            rd_word = 32'h00000000;
        end
    end

    assign hrdata = rd_word;

endmodule
`default_nettype wire

//--- logic/spt_pkg.sv
// constants and types shared by the clock prescale, trim and sleep block
package spt_pkg;

    // register word indexes; byte address is four times the index
    localparam logic [7:0] IDX_DIV_CTRL = 8'h26;
    localparam logic [7:0] IDX_OSC_TRIM = 8'h27;
    localparam logic [7:0] IDX_MCU_CTRL = 8'h28;
    localparam logic [7:0] IDX_SLEEP_STAT = 8'h29;
    localparam logic [11:0] ADDR_DIV_CTRL = {2'b00, IDX_DIV_CTRL, 2'b00};
    localparam logic [11:0] ADDR_OSC_TRIM = {2'b00, IDX_OSC_TRIM, 2'b00};
    localparam logic [11:0] ADDR_MCU_CTRL = {2'b00, IDX_MCU_CTRL, 2'b00};
    localparam logic [11:0] ADDR_SLEEP_STAT = {2'b00, IDX_SLEEP_STAT, 2'b00};

    // clock_divider_control fields
    localparam int DCC_UNLOCK_BIT = 7;
    localparam int DCC_SEL_MSB = 3;
    localparam logic [7:0] DCC_UNLOCK_WORD = 8'h80;
    localparam logic [3:0] DCC_SEL_RST_PLAIN = 4'h0;
    localparam logic [3:0] DCC_SEL_RST_DIV8 = 4'h3;
    localparam logic [3:0] DCC_SEL_MAX = 4'h8;

    // oscillator_trim fields
    localparam int TRIM_RANGE_BIT = 7;
    localparam logic [7:0] TRIM_RST = 8'h00;

    // mcu_control_register fields
    localparam int MCU_SLEEP_ALLOW_BIT = 0;
    localparam int MCU_MODE_LSB = 1;
    localparam int MCU_MODE_MSB = 2;

    // timing counts, in cycles
    localparam logic [2:0] UNLOCK_CYC = 3'h4;
    localparam logic [2:0] STANDBY_WAKE_CYC = 3'h6;
    localparam logic [2:0] PDOWN_WAKE_CYC = 3'h6;
    localparam logic [2:0] WAKE_HALT_CYC = 3'h4;

    typedef enum logic [1:0] {
        SLP_IDLE = 2'b00,
        SLP_CONV_QUIET = 2'b01,
        SLP_PDOWN = 2'b10,
        SLP_STANDBY = 2'b11
    } spt_mode_type;

    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_SLEEP = 4'b0010,
        ST_START = 4'b0100,
        ST_HALT = 4'b1000
    } spt_state_type;

endpackage

//--- logic/spt_ctl_if.sv
// internal carrier between the top and its divider and wake qualifier
`timescale 1ns/100ps
`default_nettype none
interface spt_ctl_if;
    import spt_pkg::*;
    logic [3:0] div_sel;
    logic div_tick;
    spt_mode_type sleep_mode;
    logic wake_hit;
    modport top (output div_sel, output sleep_mode, input div_tick, input wake_hit);
    modport divider (input div_sel, output div_tick);
    modport waker (input sleep_mode, output wake_hit);
endinterface
`default_nettype wire

//--- logic/spt_divider.sv
// glitch-free power-of-two system clock enable generator
`timescale 1ns/100ps
`default_nettype none
module spt_divider
    import spt_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    spt_ctl_if.divider ctl
);
    logic [7:0] cnt_reg;
    logic [3:0] act_sel_reg;
    logic [7:0] cur_mask;

    // period mask for a select code; reserved codes clamp to the largest
    function automatic logic [7:0] sel_mask(input logic [3:0] sel);
        logic [8:0] one_hot;
        one_hot = 9'h001 << ((sel > DCC_SEL_MAX) ? DCC_SEL_MAX : sel);
        return 8'((one_hot - 9'h001));
    endfunction

    assign cur_mask = sel_mask(act_sel_reg);
    // one enable pulse per divided period
    assign ctl.div_tick = ((cnt_reg & cur_mask) == cur_mask);

    // new factor only taken at a period boundary, so no short period
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            act_sel_reg <= DCC_SEL_RST_PLAIN;
            cnt_reg <= 8'h00;
        end else if (ctl.div_tick && (act_sel_reg != ctl.div_sel)) begin
            act_sel_reg <= ctl.div_sel;
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= 8'(cnt_reg + 8'h01);
        end
    end
endmodule
`default_nettype wire

//--- logic/spt_wake_qual.sv
// picks the interrupt sources allowed to wake the chip in each sleep mode
`timescale 1ns/100ps
`default_nettype none
module spt_wake_qual
    import spt_pkg::*;
(
    spt_ctl_if.waker ctl,
    input wire logic ext_irq_level,
    input wire logic ext_irq_edge,
    input wire logic pin_change_irq,
    input wire logic mem_ready_irq,
    input wire logic conv_done_irq,
    input wire logic other_irq,
    input wire logic wdt_irq
);
    // deeper modes only see the level form of the external line
    always_comb begin
        unique case (ctl.sleep_mode)
            SLP_IDLE: ctl.wake_hit = ext_irq_level | ext_irq_edge | pin_change_irq
                | mem_ready_irq | conv_done_irq | other_irq | wdt_irq;
            SLP_CONV_QUIET: ctl.wake_hit = ext_irq_level | pin_change_irq
                | mem_ready_irq | conv_done_irq | wdt_irq;
            SLP_PDOWN: ctl.wake_hit = ext_irq_level | pin_change_irq | wdt_irq;
            SLP_STANDBY: ctl.wake_hit = ext_irq_level | pin_change_irq | wdt_irq;
        endcase
    end
endmodule
`default_nettype wire

//--- tb/spt_clock_ctrl_chk.sv
// assertion checker for the clock prescale, trim and sleep block
`timescale 1ns/100ps
`default_nettype none
module spt_clock_ctrl_chk
    import spt_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic [7:0] factory_trim,
    input wire logic sleep_exec,
    input wire logic [7:0] oscillator_trim,
    input wire logic trim_range_select,
    input wire logic [6:0] trim_fine_tune,
    input wire logic osc_run,
    input wire logic cpu_clk_en,
    input wire logic flash_clk_en,
    input wire logic io_clk_en,
    input wire logic adc_clk_en,
    input wire logic core_halt,
    input wire logic wake_done
);
    logic rd_ph;
    logic wr_ph;
    logic [11:0] ph_addr;
    logic [7:0] hw_lo;
    logic take;
    assign hw_lo = hwdata[7:0];
    assign take = hsel && htrans[1] && hready && (haddr[31:12] == 20'h0);
    // remember which mapped transfer is in its data phase
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rd_ph <= 1'b0;
            wr_ph <= 1'b0;
            ph_addr <= 12'h000;
        end else begin
            rd_ph <= take && !hwrite;
            wr_ph <= take && hwrite;
            ph_addr <= haddr[11:0];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // sleep lasts one cycle at least, then four halted cycles
    sequence s_halted;
        core_halt [*5];
    endsequence
    // wake pulse follows the end of the halt and lasts one cycle
    sequence s_wake;
        ##[0:1] wake_done ##1 !wake_done;
    endsequence
    AST_TRIM_LOAD: assert property ($rose(resetn) |=> oscillator_trim == $past(factory_trim))
        else $error("trim not loaded from factory value");
    AST_TRIM_WRITE: assert property (wr_ph && ph_addr == ADDR_OSC_TRIM
        |=> oscillator_trim == $past(hw_lo)) else $error("trim write not applied");
    AST_TRIM_FIELDS: assert property (trim_range_select == oscillator_trim[7]
        && trim_fine_tune == oscillator_trim[6:0]) else $error("trim fields mismatch");
    AST_RSVD_ZERO: assert property (rd_ph && ph_addr == ADDR_DIV_CTRL
        |-> hrdata[31:8] == 24'h0 && hrdata[6:4] == 3'h0) else $error("reserved bits set");
    AST_CORE_TICKS: assert property (cpu_clk_en |-> !core_halt && flash_clk_en
        && io_clk_en && adc_clk_en) else $error("core tick while halted");
    AST_FLASH_CPU: assert property (flash_clk_en == cpu_clk_en)
        else $error("flash tick differs from core tick");
    AST_IO_ADC: assert property (io_clk_en |-> adc_clk_en)
        else $error("io tick without converter tick");
    AST_OSC_STOP: assert property (!osc_run |-> core_halt && !io_clk_en && !adc_clk_en)
        else $error("clock running with oscillator stopped");
    AST_SLEEP_CAUSE: assert property ($rose(core_halt) |-> $past(sleep_exec))
        else $error("halt without sleep request");
    AST_HALT_LEN: assert property ($rose(core_halt) |-> s_halted)
        else $error("halt too short");
    AST_WAKE_PULSE: assert property ($fell(core_halt) |-> s_wake)
        else $error("wake pulse missing");
endmodule
bind spt_clock_ctrl spt_clock_ctrl_chk i_chk (.mclk, .resetn, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .factory_trim, .sleep_exec, .oscillator_trim,
    .trim_range_select, .trim_fine_tune, .osc_run, .cpu_clk_en, .flash_clk_en, .io_clk_en,
    .adc_clk_en, .core_halt, .wake_done);
`default_nettype wire

//--- tb/spt_clock_ctrl_tb.sv
// self-checking bench for the clock prescale, trim and sleep block
`timescale 1ns/100ps
`default_nettype none
module spt_clock_ctrl_tb;
    import spt_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic fuse = 1'b0;
    logic slp = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] ftrim = 8'h00;
    logic [6:0] irq = 7'h00;
    logic [31:0] q;
    logic [7:0] tv[4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
    logic [6:0] nowake[4] = '{7'h00, 7'h22, 7'h1a, 7'h3a};
    logic [6:0] wakes[4] = '{7'h02, 7'h10, 7'h04, 7'h01};
    wire logic [31:0] hrdata;
    wire logic [7:0] otrim;
    wire logic [6:0] tft;
    wire logic hreadyout, hresp, trs, osc_run, cpu_en, fl_en, io_en, adc_en, halt, wdone;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    int ticks = 0;
    int io_t = 0;
    int adc_t = 0;
    int t0;
    int t1;
    int lat[4];

    spt_clock_ctrl i_dut (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .factory_trim(ftrim),
        .divide_by_eight_fuse(fuse), .sleep_exec(slp), .ext_irq_level(irq[0]),
        .ext_irq_edge(irq[1]), .pin_change_irq(irq[2]), .mem_ready_irq(irq[3]),
        .conv_done_irq(irq[4]), .other_irq(irq[5]), .wdt_irq(irq[6]),
        .oscillator_trim(otrim), .trim_range_select(trs), .trim_fine_tune(tft),
        .osc_run(osc_run), .cpu_clk_en(cpu_en), .flash_clk_en(fl_en), .io_clk_en(io_en),
        .adc_clk_en(adc_en), .core_halt(halt), .wake_done(wdone));

    // free-running clock
    always #5 mclk = ~mclk;

    // count cycles and enables away from the sampling edge; cut a hang short
    always @(negedge mclk) begin
        cyc <= cyc + 1;
        if (cpu_en === 1'b1) ticks <= ticks + 1;
        if (io_en === 1'b1) io_t <= io_t + 1;
        if (adc_en === 1'b1) adc_t <= adc_t + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            end_sim();
        end
    end

    // compare and report
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic end_sim();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // wait for hready at a rising edge; read data is taken at that same edge
    task automatic wait_rdy();
        do begin
            @(posedge mclk);
        end while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    // one single AHB-Lite transfer, entered just after a rising edge
    task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        wait_rdy();
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input string s);
        bus(a, 1'b0, 8'h00);
        check(s, q, {24'h0, e});
        check("resp", {31'h0, hresp}, 32'h0);
    endtask

    // reset with the given straps, two cycles long
    task automatic do_reset(input logic [7:0] t, input logic f);
        @(posedge mclk);
        resetn <= 1'b0;
        ftrim <= t;
        fuse <= f;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask

    // main sequence
    initial begin
        do_reset(8'ha5, 1'b0);
        rd(ADDR_OSC_TRIM, 8'ha5, "trim reset");
        rd(ADDR_DIV_CTRL, 8'h00, "sel reset plain");
        wr(12'h800, 8'h3c);
        rd(12'h800, 8'h00, "unmapped read");
        rd(ADDR_OSC_TRIM, 8'ha5, "trim after unmapped write");
        foreach (tv[i]) begin
            wr(ADDR_OSC_TRIM, tv[i]);
            rd(ADDR_OSC_TRIM, tv[i], "trim read");
            check("trim pins", {16'h0, trs, tft, otrim}, {16'h0, tv[i], tv[i]});
        end
        $display("test reset and trim done");
        wr(ADDR_DIV_CTRL, 8'h75);
        rd(ADDR_DIV_CTRL, 8'h00, "locked select");
        wr(ADDR_DIV_CTRL, 8'h81);
        rd(ADDR_DIV_CTRL, 8'h00, "impure unlock");
        wr(ADDR_DIV_CTRL, DCC_UNLOCK_WORD);
        wr(ADDR_DIV_CTRL, DCC_UNLOCK_WORD);
        rd(ADDR_DIV_CTRL, 8'h80, "unlock open");
        rd(ADDR_DIV_CTRL, 8'h00, "unlock expired");
        wr(ADDR_DIV_CTRL, DCC_UNLOCK_WORD);
        repeat (3) @(posedge mclk);
        wr(ADDR_DIV_CTRL, 8'h01);
        rd(ADDR_DIV_CTRL, 8'h00, "late select");
        wr(ADDR_DIV_CTRL, DCC_UNLOCK_WORD);
        wr(ADDR_DIV_CTRL, 8'h02);
        rd(ADDR_DIV_CTRL, 8'h02, "select in window");
        $display("test unlock done");
        do_reset(8'h3c, 1'b1);
        rd(ADDR_DIV_CTRL, 8'h03, "sel reset div8");
        rd(ADDR_OSC_TRIM, 8'h3c, "trim second reset");
        for (int c = 0; c <= 8; c++) begin
            wr(ADDR_DIV_CTRL, DCC_UNLOCK_WORD);
            wr(ADDR_DIV_CTRL, 8'(c));
            rd(ADDR_DIV_CTRL, 8'(c), "select code");
            repeat (600) @(posedge mclk);
            t0 = ticks;
            repeat (512) @(posedge mclk);
            check("core ticks", ticks - t0, 512 >> c);
        end
        $display("test divider done");
        do_reset(8'h00, 1'b0);
        wr(ADDR_MCU_CTRL, 8'h04);
        rd(ADDR_MCU_CTRL, 8'h04, "mcu ctrl");
        slp <= 1'b1;
        @(posedge mclk);
        slp <= 1'b0;
        repeat (3) @(posedge mclk);
        check("sleep not allowed", halt, 1'b0);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_MCU_CTRL, 8'(m * 2 + 1));
            slp <= 1'b1;
            @(posedge mclk);
            slp <= 1'b0;
            irq <= nowake[m];
            t0 = io_t;
            t1 = adc_t;
            repeat (20) @(posedge mclk);
            check("asleep", {halt, osc_run}, {1'b1, m != 2});
            check("io ticks", io_t - t0, (m == 0) ? 20 : 0);
            check("adc ticks", adc_t - t1, (m < 2) ? 20 : 0);
            rd(ADDR_SLEEP_STAT, 8'({m != 2, 2'(m), 4'h2}), "status");
            irq <= wakes[m];
            t0 = cyc;
            while (wdone !== 1'b1) @(negedge mclk);
            lat[m] = cyc - t0;
            @(posedge mclk);
            irq <= 7'h00;
        end
        check("noise wake", lat[1], lat[0]);
        check("pdown wake", lat[2], lat[0] + 6);
        check("standby wake", lat[3], lat[0] + 6);
        check("idle halt", lat[0], int'(WAKE_HALT_CYC) + 1);
        $display("test sleep done");
        end_sim();
    end
endmodule
`default_nettype wire
